// [include/pcd_pkg.sv]
// Constants shared by the PID datapath modules.
package pcd_pkg;
   // Data and accumulator widths.
   localparam int DATA_W = 16;
   localparam int COEF_W = 16;
   localparam int ACC_W = 32;
   // Binary point of the proportional gain and of the filter and integral coefficients.
   localparam int KP_FRAC = 8;
   localparam int COEF_FRAC = 15;
   // Output band in units of 0.1 percent of full scale: -5.0 to 105.0.
   localparam logic signed [DATA_W-1:0] MV_MIN = 16'shffce;
   localparam logic signed [DATA_W-1:0] MV_MAX = 16'sh041a;
   localparam logic signed [ACC_W-1:0] ACC_ZERO = 32'sh00000000;
   localparam logic signed [DATA_W-1:0] DATA_ZERO = 16'sh0000;
endpackage

// [include/pcd_mul_if.sv]
// Operand and product bundle between the datapath and one scaling multiplier.
`timescale 1ns/100ps
`default_nettype none
interface pcd_mul_if #(
   parameter int WA = 32,
   parameter int WB = 16
);
   logic signed [WA-1:0] a;
   logic [WB-1:0] b;
   logic signed [WA+WB:0] p;
   modport user (output a, output b, input p);
   modport unit (input a, input b, output p);
endinterface
`default_nettype wire

// [rtl/pcd_mul.sv]
// Signed-by-unsigned fixed-point multiplier with a fixed binary point.
`timescale 1ns/100ps
`default_nettype none
module pcd_mul #(
   parameter int WA = 32,
   parameter int WB = 16,
   parameter int FRAC = 15
) (
   pcd_mul_if.unit m // Operands in, scaled product out.
);
   logic signed [WA+WB:0] raw_w;

   assign raw_w = m.a * $signed({1'b0, m.b});
   assign m.p = raw_w >>> FRAC;
endmodule
`default_nettype wire

// [rtl/pcd_top.sv]
// Discrete-time PID datapath for one control loop.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Output is gain times the sum of deviation, integral and filtered derivative, each sample.
// - Derivative input passes a first-order lag weighted by eta-scaled coefficients.
// - Derivative acts on the process value change, never on the deviation.
// - Direct-acting mode raises the output when process value exceeds set value.
// - Reverse-acting mode raises the output when process value is below set value.
// - Output is clamped to the band -5.0 to 105.0 percent.
// - Proportional-only output equals gain times deviation: set minus process value when reverse-acting, process minus set value when direct-acting.
// - Integral term only runs together with the proportional term.
// - Derivative term only runs together with the proportional term.
// - Full PID output sums proportional, integral and derivative contributions.
module pcd_top #(
   parameter int DATA_W = pcd_pkg::DATA_W,
   parameter int COEF_W = pcd_pkg::COEF_W
) (
   input wire logic clk_sys_i, // System clock, 10 MHz.
   input wire logic sys_rst_i, // Asynchronous reset, active high.
   input wire logic sample_stb_i, // One-cycle sampling-cycle strobe.
   input wire logic signed [DATA_W-1:0] set_value_i, // Set value.
   input wire logic signed [DATA_W-1:0] process_value_i, // Process value.
   input wire logic [COEF_W-1:0] kp_i, // Proportional gain, 8 fraction bits.
   input wire logic [COEF_W-1:0] ki_coef_i, // Sampling cycle over integral time, 15 fraction bits.
   input wire logic [COEF_W-1:0] kd_keep_i, // Eta*TD over (tau+eta*TD), 15 fraction bits.
   input wire logic [COEF_W-1:0] kd_step_i, // TD over (tau+eta*TD), 15 fraction bits.
   input wire logic integral_en_i, // Adds the integral term (PI or PID).
   input wire logic derivative_en_i, // Adds the derivative term (PD or PID).
   input wire logic direct_act_i, // 1: direct-acting (cooling), 0: reverse-acting (heating).
   output logic signed [DATA_W-1:0] manipulated_value_o, // Clamped output, 0.1 percent units.
   output logic mv_valid_o // Pulse one cycle after each strobe.
);
   localparam int ACC_W = pcd_pkg::ACC_W;
   localparam int PW = ACC_W + COEF_W + 1;

   logic signed [ACC_W-1:0] integ_reg;
   logic signed [ACC_W-1:0] deriv_reg;
   logic signed [DATA_W-1:0] pv_prev_reg;
   logic first_reg;
   logic signed [DATA_W-1:0] mv_reg;
   logic valid_reg;

   logic signed [ACC_W-1:0] err_w;
   logic signed [ACC_W-1:0] dpv_w;
   logic signed [ACC_W-1:0] integ_next;
   logic signed [ACC_W-1:0] deriv_next;
   logic signed [ACC_W-1:0] sum_w;
   logic signed [PW-1:0] mv_prod_w;
   logic signed [DATA_W-1:0] mv_next;
   logic above_max_w;
   logic below_min_w;

   pcd_mul_if #(.WA(ACC_W), .WB(COEF_W)) int_bus ();
   pcd_mul_if #(.WA(ACC_W), .WB(COEF_W)) keep_bus ();
   pcd_mul_if #(.WA(ACC_W), .WB(COEF_W)) step_bus ();
   pcd_mul_if #(.WA(ACC_W), .WB(COEF_W)) kp_bus ();

   // ***************************************************************
   // Deviation and derivative input
   // ***************************************************************
   // Direct action flips the sign so the output rises when the process runs high.
   assign err_w = direct_act_i ? (ACC_W'(process_value_i) - ACC_W'(set_value_i))
                               : (ACC_W'(set_value_i) - ACC_W'(process_value_i));
   // The first sample after reset has no previous value, so it gives no change.
   assign dpv_w = first_reg ? pcd_pkg::ACC_ZERO
                : direct_act_i ? (ACC_W'(pv_prev_reg) - ACC_W'(process_value_i))
                               : (ACC_W'(process_value_i) - ACC_W'(pv_prev_reg));

   // ***************************************************************
   // Term arithmetic
   // ***************************************************************
   assign int_bus.a = err_w;
   assign int_bus.b = ki_coef_i;
   assign keep_bus.a = deriv_reg;
   assign keep_bus.b = kd_keep_i;
   assign step_bus.a = dpv_w;
   assign step_bus.b = kd_step_i;
   assign kp_bus.a = sum_w;
   assign kp_bus.b = kp_i;

   // Each multiplier keeps its own binary point: the gain has 8 fraction bits, the others 15.
   pcd_mul #(.WA(ACC_W), .WB(COEF_W), .FRAC(pcd_pkg::COEF_FRAC)) u_mul_int (.m(int_bus.unit));
   pcd_mul #(.WA(ACC_W), .WB(COEF_W), .FRAC(pcd_pkg::COEF_FRAC)) u_mul_keep (.m(keep_bus.unit));
   pcd_mul #(.WA(ACC_W), .WB(COEF_W), .FRAC(pcd_pkg::COEF_FRAC)) u_mul_step (.m(step_bus.unit));
   pcd_mul #(.WA(ACC_W), .WB(COEF_W), .FRAC(pcd_pkg::KP_FRAC)) u_mul_kp (.m(kp_bus.unit));

   // The accumulators wrap on overflow and have no anti-windup, so software must keep the
   // gains small enough that the integral stays inside its 32-bit range.
   // Proportional is always on, so integral or derivative never run alone.
   assign integ_next = integral_en_i ? (ACC_W'(int_bus.p) + integ_reg) : pcd_pkg::ACC_ZERO;
   assign deriv_next = derivative_en_i ? (ACC_W'(keep_bus.p) - ACC_W'(step_bus.p))
                                       : pcd_pkg::ACC_ZERO;
   assign sum_w = err_w + integ_next + deriv_next;
   assign mv_prod_w = kp_bus.p;
   // The band is tested at full product width so that a large product cannot wrap into it.
   assign above_max_w = mv_prod_w > PW'(pcd_pkg::MV_MAX);
   assign below_min_w = mv_prod_w < PW'(pcd_pkg::MV_MIN);
   assign mv_next = above_max_w ? pcd_pkg::MV_MAX
                  : below_min_w ? pcd_pkg::MV_MIN
                  : DATA_W'(mv_prod_w);

   // ***************************************************************
   // Stored state
   // ***************************************************************
   // State moves only on a strobe; a strobe held high recomputes on every cycle.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         integ_reg <= pcd_pkg::ACC_ZERO;
         deriv_reg <= pcd_pkg::ACC_ZERO;
         pv_prev_reg <= pcd_pkg::DATA_ZERO;
         first_reg <= 1'b1;
         mv_reg <= pcd_pkg::DATA_ZERO;
      end
      else if (sample_stb_i)
      begin
         integ_reg <= integ_next;
         deriv_reg <= deriv_next;
         pv_prev_reg <= process_value_i;
         first_reg <= 1'b0;
         mv_reg <= mv_next;
      end
   end

   // The valid pulse follows every strobe, even one that repeats the last inputs.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         valid_reg <= 1'b0;
      else
         valid_reg <= sample_stb_i;
   end

   assign manipulated_value_o = mv_reg;
   assign mv_valid_o = valid_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   a_mv_upper_bound: assert property (manipulated_value_o <= pcd_pkg::MV_MAX)
      else $error("Output above upper limit.");
   a_mv_lower_bound: assert property (manipulated_value_o >= pcd_pkg::MV_MIN)
      else $error("Output below lower limit.");
   a_mv_sum_result: assert property (sample_stb_i && mv_prod_w <= PW'(pcd_pkg::MV_MAX)
         && mv_prod_w >= PW'(pcd_pkg::MV_MIN) |=> mv_valid_o && manipulated_value_o == $past(DATA_W'(mv_prod_w)))
      else $error("Output does not match the summed terms.");
   a_p_only_gain: assert property (sample_stb_i && !integral_en_i && !derivative_en_i && !direct_act_i
         |-> sum_w == ACC_W'(set_value_i) - ACC_W'(process_value_i))
      else $error("Proportional-only sum is not the deviation.");
   a_integ_gated: assert property (sample_stb_i && !integral_en_i |=> integ_reg == pcd_pkg::ACC_ZERO)
      else $error("Integral stored while disabled.");
   a_deriv_gated: assert property (sample_stb_i && !derivative_en_i |=> deriv_reg == pcd_pkg::ACC_ZERO)
      else $error("Derivative stored while disabled.");
   a_no_sv_kick: assert property (sample_stb_i && derivative_en_i && !first_reg
         && process_value_i == pv_prev_reg && deriv_reg == pcd_pkg::ACC_ZERO |=> deriv_reg == pcd_pkg::ACC_ZERO)
      else $error("Derivative reacts without a process value change.");
   a_state_hold: assert property (!sample_stb_i |=> $stable(integ_reg) && $stable(deriv_reg)
         && $stable(manipulated_value_o))
      else $error("State changed without a strobe.");
   a_direct_rise: assert property (sample_stb_i && direct_act_i && !integral_en_i && !derivative_en_i
         && process_value_i > set_value_i |=> manipulated_value_o >= pcd_pkg::DATA_ZERO)
      else $error("Direct action output fell with process above set.");
   a_reverse_rise: assert property (sample_stb_i && !direct_act_i && !integral_en_i && !derivative_en_i
         && process_value_i < set_value_i |=> manipulated_value_o >= pcd_pkg::DATA_ZERO)
      else $error("Reverse action output fell with process below set.");
   a_valid_pulse: assert property (sample_stb_i |=> mv_valid_o ##1 (mv_valid_o == $past(sample_stb_i)))
      else $error("Valid pulse does not follow the strobe.");

   // ***************************************************************
   // Checks on reset, strobe and stored state
   // ***************************************************************
   a_reset_clears_state: assert property ($fell(sys_rst_i) |-> integ_reg == pcd_pkg::ACC_ZERO
         && deriv_reg == pcd_pkg::ACC_ZERO)
      else $error("Integral or derivative not cleared by reset.");
   a_mv_reset_zero: assert property ($fell(sys_rst_i)
         |-> manipulated_value_o == pcd_pkg::DATA_ZERO && !mv_valid_o)
      else $error("Output not cleared by reset.");
   a_valid_quiet: assert property (!sample_stb_i |=> !mv_valid_o)
      else $error("Valid pulse without a strobe.");
   a_pv_tracked: assert property (sample_stb_i |=> pv_prev_reg == $past(process_value_i))
      else $error("Previous process value not stored at the strobe.");
   a_first_cleared: assert property (sample_stb_i |=> !first_reg)
      else $error("First-sample flag survives a strobe.");
   a_pv_hold: assert property (!sample_stb_i |=> $stable(pv_prev_reg)
         && $stable(first_reg))
      else $error("Previous process value changed without a strobe.");

   // ***************************************************************
   // Checks on the integral and derivative terms
   // ***************************************************************
   a_first_no_change: assert property (sample_stb_i && first_reg |-> dpv_w == pcd_pkg::ACC_ZERO)
      else $error("First sample after reset sees a process value change.");
   a_deriv_first_zero: assert property (sample_stb_i && first_reg && deriv_reg == pcd_pkg::ACC_ZERO
         |=> deriv_reg == pcd_pkg::ACC_ZERO)
      else $error("Derivative kicks on the first sample.");
   a_deriv_decay: assert property (sample_stb_i && derivative_en_i && !first_reg && !kd_keep_i[COEF_W-1]
         && process_value_i == pv_prev_reg && deriv_reg < pcd_pkg::ACC_ZERO
         |=> deriv_reg <= pcd_pkg::ACC_ZERO && deriv_reg >= $past(deriv_reg))
      else $error("Derivative does not decay toward zero with a steady process value.");
   a_integ_pos: assert property (sample_stb_i && integral_en_i && integ_reg == pcd_pkg::ACC_ZERO
         && err_w > pcd_pkg::ACC_ZERO |=> integ_reg >= pcd_pkg::ACC_ZERO)
      else $error("Integral moved against a positive deviation.");
   a_integ_neg: assert property (sample_stb_i && integral_en_i && integ_reg == pcd_pkg::ACC_ZERO
         && err_w < pcd_pkg::ACC_ZERO |=> integ_reg <= pcd_pkg::ACC_ZERO)
      else $error("Integral moved against a negative deviation.");

   // ***************************************************************
   // Checks on action direction and clamping
   // ***************************************************************
   a_p_only_direct: assert property (sample_stb_i && !integral_en_i && !derivative_en_i && direct_act_i
         |-> sum_w == ACC_W'(process_value_i) - ACC_W'(set_value_i))
      else $error("Direct proportional-only sum is not the reversed deviation.");
   a_direct_fall: assert property (sample_stb_i && direct_act_i && !integral_en_i && !derivative_en_i
         && process_value_i < set_value_i |=> manipulated_value_o <= pcd_pkg::DATA_ZERO)
      else $error("Direct action output rose with process below set.");
   a_reverse_fall: assert property (sample_stb_i && !direct_act_i && !integral_en_i && !derivative_en_i
         && process_value_i > set_value_i |=> manipulated_value_o <= pcd_pkg::DATA_ZERO)
      else $error("Reverse action output rose with process above set.");
   a_clamp_high: assert property (sample_stb_i && mv_prod_w > PW'(pcd_pkg::MV_MAX)
         |=> manipulated_value_o == pcd_pkg::MV_MAX)
      else $error("Output not held at the upper limit.");
   a_clamp_low: assert property (sample_stb_i && mv_prod_w < PW'(pcd_pkg::MV_MIN)
         |=> manipulated_value_o == pcd_pkg::MV_MIN)
      else $error("Output not held at the lower limit.");
endmodule
`default_nettype wire

// [tb/pid_control_datapath_bench.sv]
// Self-checking testbench for the PID datapath.
`timescale 1ns/100ps
`default_nettype none
module pid_control_datapath_bench;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sample_stb_i = 1'b0;
   logic signed [15:0] set_value_i = 16'sh0000;
   logic signed [15:0] process_value_i = 16'sh0000;
   logic [15:0] kp_i = 16'h0100;
   logic [15:0] ki_coef_i = 16'h2000;
   logic [15:0] kd_keep_i = 16'h4000;
   logic [15:0] kd_step_i = 16'h4000;
   logic integral_en_i = 1'b0;
   logic derivative_en_i = 1'b0;
   logic direct_act_i = 1'b0;
   logic signed [15:0] manipulated_value_o;
   logic mv_valid_o;
   int failures = 0;
   int comparisons = 0;
   int seed = 32'h2eabec3c;
   longint m_int, m_der;
   logic signed [15:0] m_pv, m_last;
   logic m_first;
   always #50 clk_sys_i = ~clk_sys_i;
   pcd_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sample_stb_i(sample_stb_i),
      .set_value_i(set_value_i), .process_value_i(process_value_i), .kp_i(kp_i), .ki_coef_i(ki_coef_i),
      .kd_keep_i(kd_keep_i), .kd_step_i(kd_step_i), .integral_en_i(integral_en_i),
      .derivative_en_i(derivative_en_i), .direct_act_i(direct_act_i),
      .manipulated_value_o(manipulated_value_o), .mv_valid_o(mv_valid_o));
   // ****************************************
   // Reference model and drivers
   // ****************************************
   function automatic logic signed [15:0] model(input longint sv, input longint pv);
      longint e, dpv, sum, mv;
      e = direct_act_i ? pv - sv : sv - pv;
      dpv = m_first ? 0 : (direct_act_i ? longint'(m_pv) - pv : pv - longint'(m_pv));
      m_int = integral_en_i ? longint'(int'(m_int + ((longint'(ki_coef_i) * e) >>> 15))) : 0;
      m_der = derivative_en_i ? longint'(int'(((longint'(kd_keep_i) * m_der) >>> 15)
         - ((longint'(kd_step_i) * dpv) >>> 15))) : 0;
      sum = longint'(int'(e + m_int + m_der));
      mv = (longint'(kp_i) * sum) >>> 8;
      m_pv = 16'(pv);
      m_first = 1'b0;
      if (mv > pcd_pkg::MV_MAX) mv = pcd_pkg::MV_MAX;
      if (mv < pcd_pkg::MV_MIN) mv = pcd_pkg::MV_MIN;
      return 16'(mv);
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input logic signed [15:0] sv, input logic signed [15:0] pv);
      set_value_i = sv;
      process_value_i = pv;
      sample_stb_i = 1'b1;
      m_last = model(sv, pv);
      @(negedge clk_sys_i);
      check(manipulated_value_o, m_last, "output");
      check({15'h0000, mv_valid_o}, 16'h0001, "valid");
   endtask
   task automatic idle;
      sample_stb_i = 1'b0;
      @(negedge clk_sys_i);
      check({15'h0000, mv_valid_o}, 16'h0000, "valid low");
      check(manipulated_value_o, m_last, "held");
   endtask
   task automatic mode(input logic i, input logic d, input logic a);
      integral_en_i = i;
      derivative_en_i = d;
      direct_act_i = a;
   endtask
   task automatic do_reset;
      sys_rst_i = 1'b1;
      sample_stb_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      m_int = 0;
      m_der = 0;
      m_pv = 16'sh0000;
      m_last = 16'sh0000;
      m_first = 1'b1;
      check(manipulated_value_o, 16'h0000, "reset output");
      check({15'h0000, mv_valid_o}, 16'h0000, "reset valid");
   endtask
   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      do_reset();
      mode(1'b0, 1'b0, 1'b0);
      step(16'sd500, 16'sd300);
      mode(1'b0, 1'b0, 1'b1);
      step(16'sd500, 16'sd300);
      step(16'sd300, 16'sd500);
      kp_i = 16'h1000;
      step(16'sd1000, 16'sd0);
      mode(1'b0, 1'b0, 1'b0);
      step(16'sd0, 16'sd1000);
      step(16'sd1000, 16'sd0);
      kp_i = 16'h0100;
      mode(1'b0, 1'b1, 1'b0);
      step(16'sd100, 16'sd0);
      step(16'sd100, 16'sd200);
      step(16'sd900, 16'sd200);
      step(16'sd900, 16'sd260);
      mode(1'b1, 1'b0, 1'b0);
      repeat (4) step(16'sd600, 16'sd400);
      idle();
      repeat (60)
      begin
         mode(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
         kp_i = 16'($random(seed)) & 16'h03ff;
         ki_coef_i = 16'($random(seed)) & 16'h0fff;
         kd_keep_i = 16'($random(seed)) & 16'h7fff;
         kd_step_i = 16'($random(seed)) & 16'h7fff;
         step(16'($random(seed)) & 16'h03ff, 16'($random(seed)) & 16'h03ff);
         if (($random(seed) & 3) == 0) idle();
      end
      do_reset();
      mode(1'b1, 1'b1, 1'b0);
      step(16'sd300, 16'sd700);
      idle();
      results();
   end
   initial
   begin
      #200000;
      failures++;
      results();
   end
endmodule
`default_nettype wire
